// *** npr_nco_preset_bank.sv ***
// Function
// - Channel A: four 32-bit read/write frequency words, reset 0xC0000000.
// - Channel A: each preset has a 16-bit read/write phase word, reset 0.
// - Channel B: four independent 32-bit frequency words, reset 0xC0000000.
// - Channel B: each preset has a 16-bit read/write phase word, reset 0.
// - In interleaved mode channel B words never reach the oscillator.
// - Phase word is left-justified into 32 bits for the accumulator.
// - Frequency word passes unchanged; signed or unsigned both valid.
`timescale 1ns/1ps
`default_nettype none
module npr_nco_preset_bank #(
  parameter int NUM_PRESETS = npr_pkg::NUM_PRESETS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Serial control port
  input wire logic csN,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic sdoOe,
  // Converter mode
  input wire logic desMode,
  // Oscillator datapath
  output logic [NUM_PRESETS-1:0][31:0] freqWordA,
  output logic [NUM_PRESETS-1:0][31:0] phaseOffsetA,
  output logic [NUM_PRESETS-1:0][31:0] freqWordB,
  output logic [NUM_PRESETS-1:0][31:0] phaseOffsetB
);
  npr_reg_if regIf ();

  npr_serial_port u_port (
    .clk(clk),
    .reset(reset),
    .csN(csN),
    .sclk(sclk),
    .sdi(sdi),
    .sdo(sdo),
    .sdoOe(sdoOe),
    .regIf(regIf)
  );

  function automatic logic [14:0] bankOffset(input logic [14:0] a);
    return a - npr_pkg::BANK_BASE;
  endfunction : bankOffset

  logic [1:0][NUM_PRESETS-1:0][31:0] freq_ff;
  logic [1:0][NUM_PRESETS-1:0][15:0] phase_ff;
  logic [NUM_PRESETS-1:0][31:0] freqA_ff;
  logic [NUM_PRESETS-1:0][31:0] phaseA_ff;
  logic [NUM_PRESETS-1:0][31:0] freqB_ff;
  logic [NUM_PRESETS-1:0][31:0] phaseB_ff;

  // Address decode
  wire [14:0] offs = bankOffset(regIf.addr);
  wire inBank = (regIf.addr >= npr_pkg::BANK_BASE) &&
                (offs < npr_pkg::BANK_SPAN);
  wire selChan = offs[npr_pkg::CHAN_BIT];
  wire [1:0] selPreset = offs[npr_pkg::PRESET_LSB +: 2];
  wire selPhase = offs[npr_pkg::PHASE_BIT];
  wire [1:0] selByte = offs[1:0];
  // Phase words hold two bytes; the upper two lanes read as zero
  wire hit = inBank & (~selPhase | ~selByte[1]);
  wire wrFreqHit = regIf.wrStb & hit & ~selPhase;
  wire wrPhaseHit = regIf.wrStb & hit & selPhase;

  // Read path
  wire [31:0] rdWord = selPhase ?
    {npr_pkg::PHASE_PAD, phase_ff[selChan][selPreset]} :
    freq_ff[selChan][selPreset];
  wire [7:0] rdByte = rdWord[8*selByte +: 8];
  assign regIf.rdata = hit ? rdByte : npr_pkg::RDATA_NONE;

  for (genvar c = 0; c < 2; c++)
  begin : g_chan
    for (genvar p = 0; p < NUM_PRESETS; p++)
    begin : g_preset
      wire selThis = (selChan == c) && (selPreset == p);
      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
        begin
          freq_ff[c][p] <= npr_pkg::FREQ_RESET;
          phase_ff[c][p] <= npr_pkg::PHASE_RESET;
        end
        else
        begin
          if (wrFreqHit && selThis)
            freq_ff[c][p][8*selByte +: 8] <= regIf.wdata;
          if (wrPhaseHit && selThis)
            phase_ff[c][p][8*selByte[0] +: 8] <= regIf.wdata;
        end
      end
    end
  end

  // Datapath words; channel B follows channel A in interleaved mode
  for (genvar p = 0; p < NUM_PRESETS; p++)
  begin : g_out
    wire [31:0] srcFreqB = desMode ? freq_ff[0][p] : freq_ff[1][p];
    wire [15:0] srcPhaseB = desMode ? phase_ff[0][p] : phase_ff[1][p];
    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
      begin
        freqA_ff[p] <= npr_pkg::FREQ_RESET;
        phaseA_ff[p] <= {npr_pkg::PHASE_RESET, npr_pkg::PHASE_PAD};
        freqB_ff[p] <= npr_pkg::FREQ_RESET;
        phaseB_ff[p] <= {npr_pkg::PHASE_RESET, npr_pkg::PHASE_PAD};
      end
      else
      begin
        freqA_ff[p] <= freq_ff[0][p];
        phaseA_ff[p] <= {phase_ff[0][p], npr_pkg::PHASE_PAD};
        freqB_ff[p] <= srcFreqB;
        phaseB_ff[p] <= {srcPhaseB, npr_pkg::PHASE_PAD};
      end
    end
  end

  assign freqWordA = freqA_ff;
  assign phaseOffsetA = phaseA_ff;
  assign freqWordB = freqB_ff;
  assign phaseOffsetB = phaseB_ff;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  property freqWriteA;
    logic [1:0] p;
    logic [1:0] b;
    logic [7:0] d;
    (wrFreqHit && !selChan, p = selPreset, b = selByte, d = regIf.wdata)
      |-> ##2 freqWordA[p][8*b +: 8] == d;
  endproperty
  chk_freq_a_write: assert property (freqWriteA)
    else $error("channel A frequency byte not stored");

  property phaseWriteA;
    logic [1:0] p;
    logic b;
    logic [7:0] d;
    (wrPhaseHit && !selChan, p = selPreset, b = selByte[0],
      d = regIf.wdata) |-> ##2 phaseOffsetA[p][16 + 8*b +: 8] == d;
  endproperty
  chk_phase_a_write: assert property (phaseWriteA)
    else $error("channel A phase byte not stored");

  property freqWriteB;
    logic [1:0] p;
    logic [1:0] b;
    logic [7:0] d;
    (wrFreqHit && selChan, p = selPreset, b = selByte, d = regIf.wdata)
      ##1 !desMode |=> freqWordB[p][8*b +: 8] == d;
  endproperty
  chk_freq_b_write: assert property (freqWriteB)
    else $error("channel B frequency byte not stored");

  property phaseWriteB;
    logic [1:0] p;
    logic b;
    logic [7:0] d;
    (wrPhaseHit && selChan, p = selPreset, b = selByte[0],
      d = regIf.wdata) ##1 !desMode |=> phaseOffsetB[p][16 + 8*b +: 8] == d;
  endproperty
  chk_phase_b_write: assert property (phaseWriteB)
    else $error("channel B phase byte not stored");

  chk_des_ignores_b: assert property (
    desMode |=> freqWordB == freqWordA && phaseOffsetB == phaseOffsetA)
    else $error("channel B words leak in interleaved mode");

  chk_phase_left_just: assert property (
    ##1 phaseOffsetA[0] == {$past(phase_ff[0][0]), 16'h0000})
    else $error("phase word not left-justified");

  chk_freq_word_pass: assert property (
    ##1 freqWordA == $past(freq_ff[0]))
    else $error("frequency word altered on way to datapath");

  chk_preset_present: assert property (
    !desMode |=> freqWordB == $past(freq_ff[1]))
    else $error("channel B presets not presented");

  chk_reset_values: assert property (
    $past(reset) |-> freqWordA[3] == 32'hC0000000 &&
      freqWordB[0] == 32'hC0000000 && phaseOffsetB[0] == 32'h00000000)
    else $error("wrong value after reset");

  // Read drive must drop between frames
  chk_oe_idle: assert property (
    csN |=> !sdoOe)
    else $error("serial output driven outside a frame");

  // Unmapped and reserved bytes read as zero
  chk_unmapped_zero: assert property (
    !hit |-> regIf.rdata == 8'h00)
    else $error("unmapped byte reads nonzero");

  // A write strobe lasts exactly one cycle
  chk_stb_single: assert property (
    regIf.wrStb |=> !regIf.wrStb)
    else $error("write strobe longer than one cycle");

  // Channel A phase output resets to zero
  chk_reset_phase_a: assert property (
    $past(reset) |-> phaseOffsetA == '0 && freqWordA[0] == 32'hC0000000)
    else $error("wrong channel A value after reset");

  cov_write_phase_b: cover property (wrPhaseHit && selChan && !desMode);
  cov_write_a_des: cover property (wrFreqHit && !selChan && desMode);
  cov_write_a3: cover property (
    regIf.wrStb && regIf.addr == npr_pkg::OFS_FREQ_CHAN_A_PRESET3);
  cov_write_b_des: cover property (wrFreqHit && selChan && desMode);
  cov_read_frame: cover property (sdoOe && hit);
endmodule : npr_nco_preset_bank
`default_nettype wire

// *** npr_pkg.sv ***
`default_nettype none
package npr_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int NUM_PRESETS = 4;
  // Preset bank window in the serial address space
  localparam logic [14:0] BANK_BASE = 15'h220;
  localparam logic [14:0] BANK_SPAN = 15'h040;
  localparam int CHAN_BIT = 5;
  localparam int PRESET_LSB = 3;
  localparam int PHASE_BIT = 2;
  localparam logic [14:0] OFS_FREQ_CHAN_A_PRESET3 = 15'h238;
  localparam logic [14:0] OFS_PHASE_CHAN_A_PRESET3 = 15'h23C;
  localparam logic [14:0] OFS_FREQ_CHAN_B_PRESET0 = 15'h240;
  localparam logic [14:0] OFS_PHASE_CHAN_B_PRESET0 = 15'h244;
  localparam logic [14:0] OFS_FREQ_CHAN_B_PRESET1 = 15'h248;
  localparam logic [14:0] OFS_PHASE_CHAN_B_PRESET1 = 15'h24C;
  localparam logic [14:0] OFS_FREQ_CHAN_B_PRESET2 = 15'h250;
  localparam logic [14:0] OFS_PHASE_CHAN_A_PRESET2 = 15'h234;
  localparam logic [31:0] FREQ_RESET = 32'hC0000000;
  localparam logic [15:0] PHASE_RESET = 16'h0000;
  localparam logic [15:0] PHASE_PAD = 16'h0000;
  localparam logic [7:0] RDATA_NONE = 8'h00;
  // Serial frame: R/W bit, 15 address bits, 8 data bits
  localparam logic [4:0] HDR_LAST = 5'h0F;
  localparam logic [4:0] DATA_FIRST = 5'h10;
  localparam logic [4:0] FRAME_LAST = 5'h17;
  localparam logic [4:0] FRAME_BITS = 5'h18;
endpackage : npr_pkg
`default_nettype wire

// *** npr_reg_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface npr_reg_if;
  logic wrStb;
  logic [14:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport port (output wrStb, output addr, output wdata, input rdata);
  modport bank (input wrStb, input addr, input wdata, output rdata);
endinterface : npr_reg_if
`default_nettype wire

// *** npr_serial_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module npr_serial_port (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Serial control pins
  input wire logic csN,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic sdoOe,
  // Register access
  npr_reg_if.port regIf
);
  logic sclkPrev_ff;
  logic [4:0] bitCnt_ff;
  logic [15:0] shiftIn_ff;
  logic isRead_ff;
  logic loadPend_ff;
  logic [14:0] addr_ff;
  logic [7:0] wdata_ff;
  logic wrStb_ff;
  logic [7:0] rdShift_ff;
  logic sdo_ff;
  logic sdoOe_ff;

  wire sclkRise = ~csN & sclk & ~sclkPrev_ff;
  wire sclkFall = ~csN & ~sclk & sclkPrev_ff;
  wire shiftOn = sclkRise & (bitCnt_ff != npr_pkg::FRAME_BITS);
  wire hdrDone = shiftOn & (bitCnt_ff == npr_pkg::HDR_LAST);
  wire wrDone = shiftOn & (bitCnt_ff == npr_pkg::FRAME_LAST) & ~isRead_ff;
  wire rdOut = sclkFall & isRead_ff & (bitCnt_ff >= npr_pkg::DATA_FIRST);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sclkPrev_ff <= 1'b0;
      bitCnt_ff <= 5'h00;
      shiftIn_ff <= 16'h0000;
      isRead_ff <= 1'b0;
      loadPend_ff <= 1'b0;
      addr_ff <= 15'h0000;
      wdata_ff <= 8'h00;
      wrStb_ff <= 1'b0;
      rdShift_ff <= 8'h00;
      sdo_ff <= 1'b0;
      sdoOe_ff <= 1'b0;
    end
    else
    begin
      sclkPrev_ff <= sclk;
      wrStb_ff <= wrDone;
      loadPend_ff <= hdrDone & shiftIn_ff[14];
      if (csN)
      begin
        bitCnt_ff <= 5'h00;
        sdoOe_ff <= 1'b0;
      end
      else if (shiftOn)
      begin
        shiftIn_ff <= {shiftIn_ff[14:0], sdi};
        bitCnt_ff <= bitCnt_ff + 5'h01;
      end
      if (hdrDone)
      begin
        isRead_ff <= shiftIn_ff[14];
        addr_ff <= {shiftIn_ff[13:0], sdi};
      end
      if (wrDone)
        wdata_ff <= {shiftIn_ff[6:0], sdi};
      if (loadPend_ff)
        rdShift_ff <= regIf.rdata;
      else if (rdOut)
        rdShift_ff <= {rdShift_ff[6:0], 1'b0};
      if (rdOut)
      begin
        sdo_ff <= rdShift_ff[7];
        sdoOe_ff <= 1'b1;
      end
    end
  end

  assign regIf.wrStb = wrStb_ff;
  assign regIf.addr = addr_ff;
  assign regIf.wdata = wdata_ff;
  assign sdo = sdo_ff;
  assign sdoOe = sdoOe_ff;
endmodule : npr_serial_port
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk;
  logic reset;
  logic csN;
  logic sclk;
  logic sdi;
  logic desMode;
  logic sdo;
  logic sdoOe;
  logic [3:0][31:0] freqWordA;
  logic [3:0][31:0] phaseOffsetA;
  logic [3:0][31:0] freqWordB;
  logic [3:0][31:0] phaseOffsetB;
  logic [7:0] mdl [64];
  int error_cnt = 0;
  int n_compared = 0;

  npr_nco_preset_bank #(.NUM_PRESETS(4)) dut (
    .clk(clk), .reset(reset), .csN(csN), .sclk(sclk), .sdi(sdi),
    .sdo(sdo), .sdoOe(sdoOe), .desMode(desMode),
    .freqWordA(freqWordA), .phaseOffsetA(phaseOffsetA),
    .freqWordB(freqWordB), .phaseOffsetB(phaseOffsetB)
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic cmpByte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmpByte

  task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmpWord

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  // One frame of nb bits; sclk phases last two clocks each
  task automatic spi(input logic rw, input logic [14:0] a,
    input logic [7:0] wd, input int nb, output logic [7:0] rdv);
    logic [23:0] fr;
    fr = {rw, a, wd};
    rdv = 8'h00;
    csN = 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      sdi = fr[23-i];
      cyc(2);
      if (i >= 16)
        rdv = {rdv[6:0], sdo};
      if (i == 16 && rw)
        cmpByte({7'h00, sdoOe}, 8'h01);
      sclk = 1'b1;
      cyc(2);
      sclk = 1'b0;
    end
    cyc(2);
    csN = 1'b1;
    cyc(2);
    // Read drive released once the frame is over
    cmpByte({7'h00, sdoOe}, 8'h00);
  endtask : spi

  // Short frames are dropped; bytes 6 and 7 of a preset are reserved
  task automatic wr(input logic [14:0] a, input logic [7:0] d, input int nb);
    logic [7:0] dmy;
    spi(1'b0, a, d, nb, dmy);
    if (nb == 24 && a >= 15'h220 && a < 15'h260 && a[2:1] != 2'b11)
      mdl[a-15'h220] = d;
  endtask : wr

  task automatic rdChk(input logic [14:0] a);
    logic [7:0] got;
    logic [7:0] exp;
    spi(1'b1, a, 8'h00, 24, got);
    exp = (a >= 15'h220 && a < 15'h260) ? mdl[a-15'h220] : 8'h00;
    cmpByte(got, exp);
  endtask : rdChk

  task automatic rdAll();
    for (int a = 32'h220; a < 32'h260; a++)
      rdChk(15'(a));
    rdChk(15'h260);
  endtask : rdAll

  function automatic logic [31:0] fw(input int i);
    return {mdl[i+3], mdl[i+2], mdl[i+1], mdl[i]};
  endfunction : fw

  function automatic logic [31:0] pw(input int i);
    return {mdl[i+5], mdl[i+4], 16'h0000};
  endfunction : pw

  task automatic checkOut();
    int b;
    for (int p = 0; p < 4; p++)
    begin
      b = desMode ? p * 8 : 32 + p * 8;
      cmpWord(freqWordA[p], fw(p * 8));
      cmpWord(phaseOffsetA[p], pw(p * 8));
      cmpWord(freqWordB[p], fw(b));
      cmpWord(phaseOffsetB[p], pw(b));
    end
  endtask : checkOut

  initial
  begin
    reset = 1'b1;
    csN = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
    desMode = 1'b0;
    for (int i = 0; i < 64; i++)
      mdl[i] = (i % 8 == 3) ? 8'hC0 : 8'h00;
    void'($urandom(54));
    cyc(16);
    reset = 1'b0;
    cyc(1);
    checkOut();
    rdAll();
    $display("test reset_values done");
    repeat (48)
      wr(15'h220 + 15'($urandom_range(0, 63)), 8'($urandom), 24);
    wr(15'h25F, 8'hFF, 24);
    wr(15'h260, 8'hA5, 24);
    wr(15'h238, 8'h5A, 20);
    cyc(4);
    checkOut();
    rdAll();
    $display("test random_access done");
    desMode = 1'b1;
    cyc(2);
    checkOut();
    for (int p = 0; p < 4; p++)
      wr(15'(32'h240 + p * 8), 8'($urandom), 24);
    cyc(4);
    checkOut();
    // Interleaved mode programmed through channel A only
    for (int p = 0; p < 4; p++)
      wr(15'(32'h224 + p * 8), 8'($urandom), 24);
    // Frequency change; resync would be software's job afterwards
    wr(15'h238, 8'h3C, 24);
    cyc(4);
    checkOut();
    desMode = 1'b0;
    cyc(2);
    checkOut();
    rdAll();
    $display("test interleaved_mode done");
    print_verdict();
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    $display("[FAIL] %0t timeout got %h exp %h", $time, 0, 1);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
